// ==== src/tfc_top.v ====
// Functional notes
// - four framers decoded at separate base addresses
// - 80H at 10H selects AMI receive
// - 00H at 44H selects AMI superframe transmit
// - 04H or 0CH at 44H selects T1DM
// - 20H upper bits select out-of-frame threshold
// - 04H/44H/84H at 20H select T1DM thresholds
// - 2CH selects T1DM standard/alternate, or superframe
// - 00H at 3CH enables inband code detection
// - inband codes compared against 3EH and 3FH
// - 40H: superframe, loop-carrier, or extraction off
// - write to 4AH latches framer counts
// - global register write latches all four framers
// - line violation count at 4AH/4BH
// - bit error count at 4CH/4DH
// - framing bit error count at 4EH
// - 4FH counts frame loss or alignment changes
// - datalink register enables hdlc engines in ESF
// - datalink request and exception outputs presented
`include "tfc_map.vh"

module tfc_top #(
    parameter NFR     = 4,
    parameter CHIP_ID = 8'h5a    // arbitrary identification value
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [8:0]       addr,
    input  wire [7:0]       wr_data,
    input  wire             wr_en,
    input  wire             rd_en,
    output reg  [7:0]       rd_data,
    input  wire [NFR-1:0]   lcv_evt,
    input  wire [NFR-1:0]   bee_evt,
    input  wire [NFR-1:0]   fer_evt,
    input  wire [NFR-1:0]   oof_evt,
    input  wire [NFR-1:0]   change_of_frame_alignment_evt,
    input  wire [8*NFR-1:0] ib_code,
    input  wire [NFR-1:0]   ib_code_valid,
    input  wire [NFR-1:0]   hdlc_rx_req,
    input  wire [NFR-1:0]   hdlc_rx_eom,
    input  wire [NFR-1:0]   hdlc_tx_req,
    input  wire [NFR-1:0]   hdlc_tx_udr,
    output wire [NFR-1:0]   rx_ami,
    output wire [NFR-1:0]   tx_b8zs,
    output wire [2*NFR-1:0] tx_mode,
    output wire [2*NFR-1:0] fa_mode,
    output wire [2*NFR-1:0] oof_threshold,
    output wire [2*NFR-1:0] alarm_mode,
    output wire [NFR-1:0]   alarm_alt_red,
    output wire [NFR-1:0]   inband_en,
    output wire [NFR-1:0]   loop_act_det,
    output wire [NFR-1:0]   loop_deact_det,
    output wire [NFR-1:0]   sig_extract_en,
    output wire [2*NFR-1:0] sig_mode,
    output wire [NFR-1:0]   hdlc_rx_en,
    output wire [NFR-1:0]   hdlc_tx_en,
    output wire [NFR-1:0]   receive_dl_request,
    output wire [NFR-1:0]   receive_dl_end_of_message,
    output wire [NFR-1:0]   transmit_dl_request,
    output wire [NFR-1:0]   transmit_dl_underrun
);

    // ESF wins over T1DM, T1DM over loop-carrier, so 0CH reads as T1DM
    function [1:0] fmt;
        input [7:0] v;
        begin
            if (v[`TFC_BIT_ESF])
                fmt = `TFC_FMT_ESF;
            else if (v[`TFC_BIT_T1DM])
                fmt = `TFC_FMT_T1DM;
            else if (v[`TFC_BIT_LOOPCARRIER])
                fmt = `TFC_FMT_LOOPCARRIER;
            else
                fmt = `TFC_FMT_SF;
        end
    endfunction

    // global update and id sit at framer 0, offset 0dH
    wire [6:0] ofs    = addr[6:0];
    wire [1:0] fsel   = addr[8:7];
    wire       glb_hit = (fsel == `TFC_GLOBAL_FRAMER) && (ofs == `TFC_OFS_GLOBAL);
    wire       glb_upd = wr_en && glb_hit;

    wire [8*NFR-1:0] fr_rd;
    wire [NFR-1:0]   fr_hit;

    genvar f;
    generate
        for (f = 0; f < NFR; f = f + 1) begin : g_fr
            // widen the select to the genvar's width rather than slice the genvar
            wire sel = ({30'd0, fsel} == f);
            wire wr  = wr_en && sel;

            // configuration bytes as software wrote them
            reg [7:0]  dl_q;
            reg [7:0]  rxo_q;
            reg [7:0]  cdr_q;
            reg [7:0]  fa_q;
            reg [7:0]  alm_q;
            reg [7:0]  ibc_q;
            reg [7:0]  lba_q;
            reg [7:0]  lbd_q;
            reg [7:0]  sgx_q;
            reg [7:0]  txc_q;

            // running counts and the snapshot that software reads
            reg [15:0] lcv_acc_q;
            reg [15:0] bee_acc_q;
            reg [15:0] lcv_snap_q;
            reg [15:0] bee_snap_q;
            reg [7:0]  fer_acc_q;
            reg [7:0]  fls_acc_q;
            reg [7:0]  fer_snap_q;
            reg [7:0]  fls_snap_q;

            // decoded controls, one flop per output bit
            reg        rx_ami_q;
            reg        b8zs_q;
            reg        alt_red_q;
            reg        ib_en_q;
            reg        act_q;
            reg        deact_q;
            reg        sgx_en_q;
            reg [1:0]  txm_q;
            reg [1:0]  fam_q;
            reg [1:0]  oof_q;
            reg [1:0]  almm_q;
            reg [1:0]  sgxm_q;

            // datalink enables and gated engine signals
            reg        dl_rx_q;
            reg        dl_tx_q;
            reg        rreq_q;
            reg        reom_q;
            reg        treq_q;
            reg        tudr_q;

            // read mux scratch
            reg [7:0]  rv;
            reg        hit;

            // latch on own 4AH write or the global update
            wire snap = (wr && ofs == `TFC_OFS_LCV_LO) || glb_upd;
            // alignment-change option steers which event feeds 4FH
            wire fls_evt = rxo_q[`TFC_BIT_ALIGN_CNT] ? change_of_frame_alignment_evt[f] : oof_evt[f];
            wire [7:0] code = ib_code[8*f +: 8];

            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    dl_q  <= `TFC_RST_CFG;
                    rxo_q <= `TFC_RST_CFG;
                    cdr_q <= `TFC_RST_CFG;
                    fa_q  <= `TFC_RST_CFG;
                    alm_q <= `TFC_RST_CFG;
                    ibc_q <= `TFC_RST_CFG;
                    lba_q <= `TFC_RST_LB_ACT;
                    lbd_q <= `TFC_RST_LB_DEACT;
                    sgx_q <= `TFC_RST_CFG;
                    txc_q <= `TFC_RST_CFG;
                end else if (wr) begin
                    // read-only and unmapped offsets fall through untouched
                    case (ofs)
                        `TFC_OFS_DATALINK:   dl_q  <= wr_data;
                        `TFC_OFS_RX_OPTIONS: rxo_q <= wr_data;
                        `TFC_OFS_CDR_CFG:    cdr_q <= wr_data;
                        `TFC_OFS_FA_CFG:     fa_q  <= wr_data;
                        `TFC_OFS_ALARM_CFG:  alm_q <= wr_data;
                        `TFC_OFS_INBAND_CFG: ibc_q <= wr_data;
                        `TFC_OFS_LB_ACT:     lba_q <= wr_data;
                        `TFC_OFS_LB_DEACT:   lbd_q <= wr_data;
                        `TFC_OFS_SIG_CFG:    sgx_q <= wr_data;
                        `TFC_OFS_TX_CFG:     txc_q <= wr_data;
                        default: ;
                    endcase
                end
            end

            // accumulators restart on snapshot; a same-cycle event is kept
            // as the first count of the new interval, and counts saturate
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    lcv_acc_q  <= 16'h0000;
                    bee_acc_q  <= 16'h0000;
                    fer_acc_q  <= 8'h00;
                    fls_acc_q  <= 8'h00;
                    lcv_snap_q <= 16'h0000;
                    bee_snap_q <= 16'h0000;
                    fer_snap_q <= 8'h00;
                    fls_snap_q <= 8'h00;
                end else if (snap) begin
                    lcv_snap_q <= lcv_acc_q;
                    bee_snap_q <= bee_acc_q;
                    fer_snap_q <= fer_acc_q;
                    fls_snap_q <= fls_acc_q;
                    lcv_acc_q  <= {15'h0000, lcv_evt[f]};
                    bee_acc_q  <= {15'h0000, bee_evt[f]};
                    fer_acc_q  <= {7'h00, fer_evt[f]};
                    fls_acc_q  <= {7'h00, fls_evt};
                end else begin
                    if (lcv_evt[f] && lcv_acc_q != 16'hffff)
                        lcv_acc_q <= lcv_acc_q + 16'h0001;
                    if (bee_evt[f] && bee_acc_q != 16'hffff)
                        bee_acc_q <= bee_acc_q + 16'h0001;
                    if (fer_evt[f] && fer_acc_q != 8'hff)
                        fer_acc_q <= fer_acc_q + 8'h01;
                    if (fls_evt && fls_acc_q != 8'hff)
                        fls_acc_q <= fls_acc_q + 8'h01;
                end
            end

            // decoded controls registered so every output leaves a flop
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    rx_ami_q  <= 1'b0;
                    b8zs_q    <= 1'b0;
                    txm_q     <= `TFC_FMT_SF;
                    fam_q     <= `TFC_FMT_SF;
                    oof_q     <= 2'h0;
                    almm_q    <= `TFC_FMT_SF;
                    alt_red_q <= 1'b0;
                    ib_en_q   <= 1'b0;
                    act_q     <= 1'b0;
                    deact_q   <= 1'b0;
                    sgx_en_q  <= 1'b0;
                    sgxm_q    <= `TFC_FMT_SF;
                    dl_rx_q   <= 1'b0;
                    dl_tx_q   <= 1'b0;
                    rreq_q    <= 1'b0;
                    reom_q    <= 1'b0;
                    treq_q    <= 1'b0;
                    tudr_q    <= 1'b0;
                end else begin
                    // line code and transmit format
                    rx_ami_q  <= cdr_q[`TFC_BIT_RX_AMI];
                    b8zs_q    <= txc_q[`TFC_BIT_B8ZS];
                    txm_q     <= fmt(txc_q);

                    // frame aligner and alarm integrator
                    fam_q     <= fmt(fa_q);
                    oof_q     <= fa_q[`TFC_OOF_MSB:`TFC_OOF_LSB];
                    almm_q    <= fmt(alm_q);
                    alt_red_q <= alm_q[`TFC_BIT_T1DM] && alm_q[`TFC_BIT_ALT_RED];

                    // inband codes, silenced by the disable bit
                    ib_en_q   <= !ibc_q[`TFC_BIT_INBAND_DIS];
                    act_q     <= !ibc_q[`TFC_BIT_INBAND_DIS] && ib_code_valid[f] && code == lba_q;
                    deact_q   <= !ibc_q[`TFC_BIT_INBAND_DIS] && ib_code_valid[f] && code == lbd_q;

                    // signaling extraction
                    sgx_en_q  <= !sgx_q[`TFC_BIT_SIG_DIS];
                    sgxm_q    <= sgx_q[`TFC_BIT_LOOPCARRIER] ? `TFC_FMT_LOOPCARRIER : `TFC_FMT_SF;

                    // datalink engines only run with ESF on both sides
                    dl_rx_q   <= dl_q[`TFC_BIT_DL_RX_EN] && fmt(fa_q) == `TFC_FMT_ESF
                                 && fmt(txc_q) == `TFC_FMT_ESF;
                    dl_tx_q   <= dl_q[`TFC_BIT_DL_TX_EN] && fmt(fa_q) == `TFC_FMT_ESF
                                 && fmt(txc_q) == `TFC_FMT_ESF;
                    rreq_q    <= dl_rx_q && hdlc_rx_req[f];
                    reom_q    <= dl_rx_q && hdlc_rx_eom[f];
                    treq_q    <= dl_tx_q && hdlc_tx_req[f];
                    tudr_q    <= dl_tx_q && hdlc_tx_udr[f];
                end
            end

            always @* begin
                rv  = 8'h00;
                hit = sel;
                case (ofs)
                    `TFC_OFS_DATALINK:   rv = dl_q;
                    `TFC_OFS_RX_OPTIONS: rv = rxo_q;
                    `TFC_OFS_CDR_CFG:    rv = cdr_q;
                    `TFC_OFS_FA_CFG:     rv = fa_q;
                    `TFC_OFS_ALARM_CFG:  rv = alm_q;
                    `TFC_OFS_INBAND_CFG: rv = ibc_q;
                    `TFC_OFS_LB_ACT:     rv = lba_q;
                    `TFC_OFS_LB_DEACT:   rv = lbd_q;
                    `TFC_OFS_SIG_CFG:    rv = sgx_q;
                    `TFC_OFS_TX_CFG:     rv = txc_q;

                    // counts come from the snapshot only, never the live total
                    `TFC_OFS_LCV_LO:     rv = lcv_snap_q[7:0];
                    `TFC_OFS_LCV_HI:     rv = lcv_snap_q[15:8];
                    `TFC_OFS_BEE_LO:     rv = bee_snap_q[7:0];
                    `TFC_OFS_BEE_HI:     rv = bee_snap_q[15:8];
                    `TFC_OFS_FER:        rv = fer_snap_q;
                    `TFC_OFS_FLOSS:      rv = fls_snap_q;
                    default:             hit = 1'b0;
                endcase
            end

            assign fr_rd[8*f +: 8]         = rv;
            assign fr_hit[f]               = hit;
            assign rx_ami[f]               = rx_ami_q;
            assign tx_b8zs[f]              = b8zs_q;
            assign tx_mode[2*f +: 2]       = txm_q;
            assign fa_mode[2*f +: 2]       = fam_q;
            assign oof_threshold[2*f +: 2] = oof_q;
            assign alarm_mode[2*f +: 2]    = almm_q;
            assign alarm_alt_red[f]        = alt_red_q;
            assign inband_en[f]            = ib_en_q;
            assign loop_act_det[f]         = act_q;
            assign loop_deact_det[f]       = deact_q;
            assign sig_extract_en[f]       = sgx_en_q;
            assign sig_mode[2*f +: 2]      = sgxm_q;
            assign hdlc_rx_en[f]           = dl_rx_q;
            assign hdlc_tx_en[f]           = dl_tx_q;
            assign receive_dl_request[f]        = rreq_q;
            assign receive_dl_end_of_message[f] = reom_q;
            assign transmit_dl_request[f]       = treq_q;
            assign transmit_dl_underrun[f]      = tudr_q;
        end
    endgenerate

    // read data stands for exactly one cycle; unmapped offsets read zero
    reg [7:0] rd_d;
    integer   i;
    always @* begin
        rd_d = 8'h00;
        if (glb_hit) begin
            rd_d = CHIP_ID[7:0];
        end else begin
            for (i = 0; i < NFR; i = i + 1) begin
                if (fr_hit[i])
                    rd_d = fr_rd[8*i +: 8];
            end
        end
    end

    // zero outside the answer cycle, so a stale byte never lingers
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            rd_data <= 8'h00;
        else if (rd_en)
            rd_data <= rd_d;
        else
            rd_data <= 8'h00;
    end

endmodule

// ==== shared/tfc_map.vh ====
`ifndef TFC_MAP_VH
`define TFC_MAP_VH

// per-framer offsets, addr[6:0]; framer select is addr[8:7]
`define TFC_OFS_DATALINK      7'h02
`define TFC_OFS_RX_OPTIONS    7'h03
`define TFC_OFS_GLOBAL        7'h0d
`define TFC_OFS_CDR_CFG       7'h10
`define TFC_OFS_FA_CFG        7'h20
`define TFC_OFS_ALARM_CFG     7'h2c
`define TFC_OFS_INBAND_CFG    7'h3c
`define TFC_OFS_LB_ACT        7'h3e
`define TFC_OFS_LB_DEACT      7'h3f
`define TFC_OFS_SIG_CFG       7'h40
`define TFC_OFS_TX_CFG        7'h44
`define TFC_OFS_LCV_LO        7'h4a
`define TFC_OFS_LCV_HI        7'h4b
`define TFC_OFS_BEE_LO        7'h4c
`define TFC_OFS_BEE_HI        7'h4d
`define TFC_OFS_FER           7'h4e
`define TFC_OFS_FLOSS         7'h4f

// framer bases 000/080/100/180: framer index sits above the offset
`define TFC_FRAMER_LSB        7
`define TFC_GLOBAL_FRAMER     2'h0

// field positions
`define TFC_BIT_RX_AMI        7
`define TFC_BIT_B8ZS          5
`define TFC_BIT_ESF           4
`define TFC_BIT_LOOPCARRIER   3
`define TFC_BIT_T1DM          2
`define TFC_BIT_ALT_RED       3
`define TFC_BIT_INBAND_DIS    7
`define TFC_BIT_SIG_DIS       2
`define TFC_BIT_ALIGN_CNT     0
`define TFC_BIT_DL_RX_EN      7
`define TFC_BIT_DL_TX_EN      5
`define TFC_OOF_MSB           7
`define TFC_OOF_LSB           6

// format codes
`define TFC_FMT_SF            2'h0
`define TFC_FMT_T1DM          2'h1
`define TFC_FMT_LOOPCARRIER   2'h2
`define TFC_FMT_ESF           2'h3

// reset values
`define TFC_RST_CFG           8'h00
`define TFC_RST_LB_ACT        8'h08
`define TFC_RST_LB_DEACT      8'h44

`endif

// ==== bench/tfc_monitor.sv ====
module tfc_monitor #(
    parameter NFR     = 4,
    parameter CHIP_ID = 8'h5a
) (
    input logic             clk,
    input logic             nrst,
    input logic [8:0]       addr,
    input logic             wr_en,
    input logic             rd_en,
    input logic [7:0]       rd_data,
    input logic [NFR-1:0]   ib_code_valid,
    input logic [NFR-1:0]   hdlc_rx_req,
    input logic [NFR-1:0]   hdlc_rx_eom,
    input logic [NFR-1:0]   hdlc_tx_req,
    input logic [NFR-1:0]   hdlc_tx_udr,
    input logic [NFR-1:0]   rx_ami,
    input logic [NFR-1:0]   tx_b8zs,
    input logic [2*NFR-1:0] oof_threshold,
    input logic [NFR-1:0]   loop_act_det,
    input logic [NFR-1:0]   loop_deact_det,
    input logic [2*NFR-1:0] sig_mode,
    input logic [NFR-1:0]   hdlc_rx_en,
    input logic [NFR-1:0]   hdlc_tx_en,
    input logic [NFR-1:0]   receive_dl_request,
    input logic [NFR-1:0]   receive_dl_end_of_message,
    input logic [NFR-1:0]   transmit_dl_request,
    input logic [NFR-1:0]   transmit_dl_underrun
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    rd_idle_a: assert property (!rd_en |=> rd_data == 8'h00) else $error("read data not idle");
    unmapped_rd_a: assert property (rd_en && addr[6:0] == 7'h01 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    chip_id_a: assert property (rd_en && addr == 9'h00d |=> rd_data == CHIP_ID) else $error("id read wrong");
    dl_rx_req_a: assert property (1'b1 |=> receive_dl_request == $past(hdlc_rx_req & hdlc_rx_en))
        else $error("rx request gating wrong");
    dl_rx_eom_a: assert property (1'b1 |=> receive_dl_end_of_message == $past(hdlc_rx_eom & hdlc_rx_en))
        else $error("rx eom gating wrong");
    dl_tx_req_a: assert property (1'b1 |=> transmit_dl_request == $past(hdlc_tx_req & hdlc_tx_en))
        else $error("tx request gating wrong");
    dl_tx_udr_a: assert property (1'b1 |=> transmit_dl_underrun == $past(hdlc_tx_udr & hdlc_tx_en))
        else $error("tx underrun gating wrong");
    cfg_hold_a: assert property (!$stable({rx_ami, tx_b8zs, oof_threshold}) |-> $past(wr_en) || $past(wr_en, 2))
        else $error("config output moved without write");
    loop_det_a: assert property (((loop_act_det | loop_deact_det) & ~$past(ib_code_valid)) == '0)
        else $error("loop detect without valid code");
    sig_mode_a: assert property ((sig_mode & {NFR{2'b01}}) == '0) else $error("bad signaling mode");
    cover property (rd_en && addr[6:0] == 7'h4a);
    cover property (|receive_dl_request);
    cover property (|loop_act_det);
endmodule

bind tfc_top tfc_monitor #(.NFR(NFR), .CHIP_ID(CHIP_ID)) tfc_monitor_inst (.clk, .nrst, .addr, .wr_en, .rd_en,
    .rd_data, .ib_code_valid, .hdlc_rx_req, .hdlc_rx_eom, .hdlc_tx_req, .hdlc_tx_udr, .rx_ami, .tx_b8zs,
    .oof_threshold, .loop_act_det, .loop_deact_det, .sig_mode, .hdlc_rx_en, .hdlc_tx_en, .receive_dl_request,
    .receive_dl_end_of_message, .transmit_dl_request, .transmit_dl_underrun);

// ==== bench/testbench.sv ====
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk = 0, nrst = 0, wr_en = 0, rd_en = 0;
    logic [8:0]       addr = '0;
    logic [7:0]       wr_data = '0, rd_data;
    logic [3:0]       lcv_evt = '0, bee_evt = '0, fer_evt = '0, oof_evt = '0, change_of_frame_alignment_evt = '0, ib_code_valid = '0;
    logic [3:0]       hdlc_rx_req = '0, hdlc_rx_eom = '0, hdlc_tx_req = '0, hdlc_tx_udr = '0;
    logic [31:0]      ib_code = '0;
    logic [3:0]       rx_ami, tx_b8zs, alarm_alt_red, inband_en, loop_act_det, loop_deact_det, sig_extract_en;
    logic [3:0]       hdlc_rx_en, hdlc_tx_en, receive_dl_request, receive_dl_end_of_message;
    logic [3:0]       transmit_dl_request, transmit_dl_underrun;
    logic [7:0]       tx_mode, fa_mode, oof_threshold, alarm_mode, sig_mode;
    logic [22:0]      rows [19] = '{{7'h10, 8'h80, 4'd0, 4'h1}, {7'h10, 8'h00, 4'd0, 4'h0}, {7'h44, 8'h00, 4'd1, 4'h0},
        {7'h44, 8'h04, 4'd1, 4'h1}, {7'h44, 8'h0c, 4'd1, 4'h1}, {7'h20, 8'h00, 4'd2, 4'h0}, {7'h20, 8'h40, 4'd2, 4'h1},
        {7'h20, 8'h80, 4'd2, 4'h2}, {7'h20, 8'h04, 4'd2, 4'h4}, {7'h20, 8'h44, 4'd2, 4'h5}, {7'h20, 8'h84, 4'd2, 4'h6},
        {7'h2c, 8'h04, 4'd3, 4'h1}, {7'h2c, 8'h0c, 4'd3, 4'h5}, {7'h2c, 8'h00, 4'd3, 4'h0}, {7'h3c, 8'h00, 4'd4, 4'h1},
        {7'h3c, 8'h80, 4'd4, 4'h0}, {7'h40, 8'h00, 4'd5, 4'h4}, {7'h40, 8'h08, 4'd5, 4'h6}, {7'h40, 8'h04, 4'd5, 4'h0}};
    logic [7:0]       cnt_exp [6] = '{8'h03, 8'h00, 8'h04, 8'h01, 8'h05, 8'h02};
    int               err_count = 0, checks_done = 0, cycles = 0;

    tfc_top tfc_top_inst (.clk, .nrst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .lcv_evt, .bee_evt, .fer_evt,
        .oof_evt, .change_of_frame_alignment_evt, .ib_code, .ib_code_valid, .hdlc_rx_req, .hdlc_rx_eom, .hdlc_tx_req, .hdlc_tx_udr,
        .rx_ami, .tx_b8zs, .tx_mode, .fa_mode, .oof_threshold, .alarm_mode, .alarm_alt_red, .inband_en,
        .loop_act_det, .loop_deact_det, .sig_extract_en, .sig_mode, .hdlc_rx_en, .hdlc_tx_en, .receive_dl_request,
        .receive_dl_end_of_message, .transmit_dl_request, .transmit_dl_underrun);

    always #2 clk = ~clk;

    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rd_data", e, rd_data)
    endtask

    // derived outputs trail the write edge by up to two cycles
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    function automatic logic [3:0] pick(input logic [3:0] s, input int f);
        case (s)
            4'd0: return {3'b0, rx_ami[f]};
            4'd1: return {2'b0, tx_mode[2*f+:2]};
            4'd2: return {fa_mode[2*f+:2], oof_threshold[2*f+:2]};
            4'd3: return {1'b0, alarm_alt_red[f], alarm_mode[2*f+:2]};
            4'd4: return {3'b0, inband_en[f]};
            default: return {1'b0, sig_extract_en[f], sig_mode[2*f+:2]};
        endcase
    endfunction

    initial begin
        do_reset();
        for (int i = 0; i < 19; i++) begin
            wr({i[1:0], rows[i][22:16]}, rows[i][15:8]);
            settle();
            `CHK("decode", rows[i][3:0], pick(rows[i][7:4], i % 4))
            rdc({i[1:0], rows[i][22:16]}, rows[i][15:8]);
        end
        $display("done: config rows");
        wr(9'h1be, 8'h11);
        do_reset();
        rdc(9'h1be, 8'h08);
        rdc(9'h1bf, 8'h44);
        rdc(9'h010, 8'h00);
        `CHK("rx_ami", 4'h0, rx_ami)
        `CHK("inband_en", 4'hf, inband_en)
        $display("done: reset");
        @(posedge clk);
        ib_code       <= 32'h0000_0800;
        ib_code_valid <= 4'h2;
        settle();
        `CHK("act", 2'b10, {loop_act_det[1], loop_deact_det[1]})
        @(posedge clk);
        ib_code <= 32'h0000_4400;
        settle();
        `CHK("deact", 2'b01, {loop_act_det[1], loop_deact_det[1]})
        wr(9'h0be, 8'h5a);
        ib_code <= 32'h0000_5a00;
        settle();
        `CHK("act new", 2'b10, {loop_act_det[1], loop_deact_det[1]})
        wr(9'h0bc, 8'h80);
        settle();
        `CHK("act off", 2'b00, {loop_act_det[1], loop_deact_det[1]})
        @(posedge clk);
        ib_code_valid <= 4'h0;
        $display("done: loopback codes");
        for (int i = 0; i < 260; i++) begin
            @(posedge clk);
            lcv_evt <= (i < 3) ? 4'h4 : 4'h0;
            bee_evt <= 4'h4;
            fer_evt <= (i < 5) ? 4'h4 : 4'h0;
            oof_evt <= (i < 2) ? 4'h4 : 4'h0;
        end
        @(posedge clk);
        bee_evt <= 4'h0;
        wr(9'h14a, 8'h00);
        for (int k = 0; k < 6; k++) rdc(9'h14a + 9'(k), cnt_exp[k]);
        @(posedge clk);
        lcv_evt <= 4'h4;
        @(posedge clk);
        lcv_evt <= 4'h0;
        rdc(9'h14a, 8'h03);
        wr(9'h103, 8'h01);
        wr(9'h14a, 8'h00);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            change_of_frame_alignment_evt <= 4'h4;
            oof_evt  <= (i < 2) ? 4'h4 : 4'h0;
        end
        @(posedge clk);
        change_of_frame_alignment_evt <= 4'h0;
        oof_evt  <= 4'h0;
        wr(9'h14a, 8'h00);
        rdc(9'h14f, 8'h07);
        $display("done: counters");
        @(posedge clk);
        lcv_evt <= 4'h9;
        repeat (2) @(posedge clk);
        lcv_evt <= 4'h0;
        wr(9'h00d, 8'h00);
        rdc(9'h04a, 8'h02);
        rdc(9'h1ca, 8'h02);
        rdc(9'h00d, 8'h5a);
        wr(9'h04b, 8'hff);
        rdc(9'h04b, 8'h00);
        rdc(9'h001, 8'h00);
        $display("done: global latch");
        @(posedge clk);
        hdlc_rx_req <= 4'h1;
        hdlc_rx_eom <= 4'h1;
        hdlc_tx_req <= 4'h1;
        hdlc_tx_udr <= 4'h1;
        wr(9'h002, 8'ha0);
        settle();
        `CHK("dl off", 3'b000, {hdlc_rx_en[0], hdlc_tx_en[0], receive_dl_request[0]})
        wr(9'h044, 8'h30);
        wr(9'h020, 8'h10);
        settle();
        `CHK("esf tx", 3'b111, {tx_b8zs[0], tx_mode[1:0]})
        `CHK("dl en", 2'b11, {hdlc_rx_en[0], hdlc_tx_en[0]})
        `CHK("dl out", 4'hf, {receive_dl_request[0], receive_dl_end_of_message[0], transmit_dl_request[0],
            transmit_dl_underrun[0]})
        $display("done: datalink");
        stop_test();
    end
endmodule
